/* File: ddgl_pkg.sv */
// Purpose: constants for the sdram geometry and latency configuration registers
// Assumes: apb byte addresses, 32-bit data, 20 MHz register clock
// Notes: field positions, codes, offsets and counts for the design live here; the assertions restate some as literals
package ddgl_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_KIND = 8'h00;
  localparam logic [7:0] OFS_GEOM = 8'h04;
  localparam logic [7:0] OFS_RLAT = 8'h08;
  localparam logic [7:0] OFS_WLAT = 8'h0C;
  localparam logic [7:0] OFS_ALAT = 8'h10;
  localparam logic [7:0] OFS_ACCESS_ENABLE_BIT = 8'h14;
  localparam logic [7:0] OFS_AUTO_REFRESH_ENABLE_BIT = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;

  // writable bits of each register, all else reads zero
  localparam logic [31:0] KIND_MASK = 32'h0000_0007;
  localparam logic [31:0] GEOM_MASK = 32'h1F13_0F03;
  localparam logic [31:0] RLAT_MASK = 32'h0000_000F;
  localparam logic [31:0] WLAT_MASK = 32'h0000_0007;
  localparam logic [31:0] ALAT_MASK = 32'h0000_000F;
  localparam logic [31:0] EN_MASK = 32'h0000_0001;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  // geometry field positions
  localparam int ROW_LSB = 24;
  localparam int RANK_BIT = 20;
  localparam int BANK_LSB = 16;
  localparam int COL_LSB = 8;
  localparam int BUSW_LSB = 0;

  // permitted codes
  localparam logic [2:0] KIND_DDR3 = 3'h7;
  localparam logic [4:0] ROW_MIN = 5'h0B;
  localparam logic [4:0] ROW_MAX = 5'h10;
  localparam logic RANK_ONE = 1'b0;
  localparam logic [1:0] BANK_EIGHT = 2'h3;
  localparam logic [3:0] COL_MIN = 4'h8;
  localparam logic [3:0] COL_MAX = 4'hC;
  localparam logic [1:0] BUSW_32 = 2'h2;
  localparam logic [3:0] CL_MIN = 4'h5;
  localparam logic [3:0] CL_MAX = 4'hA;
  localparam logic [2:0] CWL_MIN = 3'h5;
  localparam logic [2:0] CWL_MAX = 3'h7;
  localparam logic [3:0] AL_ZERO = 4'h0;

  // status register bit positions
  localparam int STAT_KIND_OK = 0;
  localparam int STAT_GEOM_OK = 1;
  localparam int STAT_RLAT_OK = 2;
  localparam int STAT_WLAT_OK = 3;
  localparam int STAT_ALAT_OK = 4;
  localparam int STAT_CFG_OK = 5;

  // logical address split on a 32-bit bus
  localparam int BYTE_LANE_BITS = 2;
  localparam int BANK_ADDR_BITS = 3;

  // refresh interval
  localparam int CLK_PERIOD_NS = 50;
  localparam int REFRESH_TIME_NS = 7800;
  localparam int REFRESH_CYCLES = REFRESH_TIME_NS / CLK_PERIOD_NS;
  localparam logic [15:0] REFRESH_LAST = 16'(REFRESH_CYCLES - 1);

endpackage

/* File: ddgl_addr_split.sv */
// Purpose: splits a logical byte address into bank, row and column
// Assumes: widths hold the programmed codes, which equal the widths in bits
// Notes: purely combinational, the caller registers the result
`timescale 1ns/1ps
module ddgl_addr_split (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] addr_i,
  input wire logic [4:0] row_width_i,
  input wire logic [3:0] column_width_i,
  output logic [2:0] bank_o,
  output logic [15:0] row_o,
  output logic [11:0] col_o
);

  function automatic logic [31:0] low_mask(input logic [5:0] width);
    low_mask = (32'h0000_0001 << width) - 32'h0000_0001;
  endfunction

  logic [31:0] word_addr;
  logic [31:0] after_col;
  logic [31:0] after_bank;
  logic [31:0] col_full;
  logic [31:0] row_full;

  assign word_addr = addr_i >> ddgl_pkg::BYTE_LANE_BITS;
  assign col_full = word_addr & low_mask({2'h0, column_width_i});
  assign after_col = word_addr >> column_width_i;
  assign after_bank = after_col >> ddgl_pkg::BANK_ADDR_BITS;
  assign row_full = after_bank & low_mask({1'h0, row_width_i});
  assign bank_o = after_col[2:0];
  assign col_o = col_full[11:0];
  assign row_o = row_full[15:0];

  property p_col_fits;
    @(posedge clk_i) disable iff (!rst_n_i)
    (column_width_i == 4'h8) |-> (col_o[11:8] == 4'h0);
  endproperty
  a_col_fits: assert property (p_col_fits) else $error("column exceeds programmed width");

endmodule

/* File: ddgl_regs.sv */
// Purpose: apb register bank for sdram kind, geometry and latency setup
// Assumes: rst_n_i is the power-on reset; ce_i low freezes every flop
// Notes: apb answers with one wait state; config writes refused while enabled
`timescale 1ns/1ps
module ddgl_regs (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [2:0] memory_kind_code_o,
  output logic [4:0] row_width_o,
  output logic rank_count_o,
  output logic [1:0] bank_count_o,
  output logic [3:0] column_width_o,
  output logic [1:0] ext_bus_width_o,
  output logic [3:0] cas_latency_o,
  output logic [3:0] cas_write_latency_o,
  output logic [3:0] additive_latency_o,
  output logic access_enable_bit_o,
  output logic auto_refresh_enable_bit_o,
  output logic config_valid_o,
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  output logic mem_gnt_o,
  output logic cmd_valid_o,
  output logic [2:0] cmd_bank_o,
  output logic [15:0] cmd_row_o,
  output logic [11:0] cmd_col_o,
  output logic refresh_req_o
);

  function automatic logic is_cfg(input logic [7:0] addr);
    is_cfg = (addr == ddgl_pkg::OFS_KIND) || (addr == ddgl_pkg::OFS_GEOM) ||
             (addr == ddgl_pkg::OFS_RLAT) || (addr == ddgl_pkg::OFS_WLAT) ||
             (addr == ddgl_pkg::OFS_ALAT);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = is_cfg(addr) || (addr == ddgl_pkg::OFS_ACCESS_ENABLE_BIT) ||
                (addr == ddgl_pkg::OFS_AUTO_REFRESH_ENABLE_BIT) || (addr == ddgl_pkg::OFS_STAT);
  endfunction

  logic [2:0] kind, next_kind, wlat, next_wlat, cmd_bank, next_cmd_bank, split_bank;
  logic [31:0] geom, next_geom, rdata, next_rdata, status;
  logic [3:0] rlat, next_rlat, alat, next_alat;
  logic access_enable_bit, next_access_enable_bit, auto_refresh_enable_bit, next_auto_refresh_enable_bit;
  logic ack, next_ack, err, next_err, access_start, wr_commit;
  logic [15:0] ref_cnt, next_ref_cnt, cmd_row, next_cmd_row, split_row;
  logic ref_pulse, next_ref_pulse, cmd_valid, next_cmd_valid;
  logic [11:0] cmd_col, next_cmd_col, split_col;
  logic kind_ok, geom_ok, rlat_ok, wlat_ok, alat_ok;

  default clocking cb_main @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  assign kind_ok = (kind == ddgl_pkg::KIND_DDR3);
  assign geom_ok = (geom[ddgl_pkg::ROW_LSB +: 5] >= ddgl_pkg::ROW_MIN) &&
                   (geom[ddgl_pkg::ROW_LSB +: 5] <= ddgl_pkg::ROW_MAX) &&
                   (geom[ddgl_pkg::RANK_BIT] == ddgl_pkg::RANK_ONE) &&
                   (geom[ddgl_pkg::BANK_LSB +: 2] == ddgl_pkg::BANK_EIGHT) &&
                   (geom[ddgl_pkg::COL_LSB +: 4] >= ddgl_pkg::COL_MIN) &&
                   (geom[ddgl_pkg::COL_LSB +: 4] <= ddgl_pkg::COL_MAX) &&
                   (geom[ddgl_pkg::BUSW_LSB +: 2] == ddgl_pkg::BUSW_32);
  assign rlat_ok = (rlat >= ddgl_pkg::CL_MIN) && (rlat <= ddgl_pkg::CL_MAX);
  assign wlat_ok = (wlat >= ddgl_pkg::CWL_MIN) && (wlat <= ddgl_pkg::CWL_MAX);
  assign alat_ok = (alat == ddgl_pkg::AL_ZERO);

  always_comb begin
    status = 32'h0000_0000;
    status[ddgl_pkg::STAT_KIND_OK] = kind_ok;
    status[ddgl_pkg::STAT_GEOM_OK] = geom_ok;
    status[ddgl_pkg::STAT_RLAT_OK] = rlat_ok;
    status[ddgl_pkg::STAT_WLAT_OK] = wlat_ok;
    status[ddgl_pkg::STAT_ALAT_OK] = alat_ok;
    status[ddgl_pkg::STAT_CFG_OK] = kind_ok & geom_ok & rlat_ok & wlat_ok & alat_ok;
  end

  // apb: first access cycle computes answer, second one completes
  assign access_start = ce_i & psel_i & penable_i & ~ack;
  assign wr_commit = ce_i & psel_i & penable_i & ack & pwrite_i & ~err;

  always_comb begin
    next_ack = ack;
    next_err = err;
    next_rdata = rdata;
    if (ce_i) begin
      next_ack = access_start;
      if (access_start) begin
        next_err = ~is_mapped(paddr_i) |
                   (pwrite_i & is_cfg(paddr_i) & (access_enable_bit | auto_refresh_enable_bit));
        if (pwrite_i) begin
          next_rdata = 32'h0000_0000;
        end else if (paddr_i == ddgl_pkg::OFS_KIND) begin
          next_rdata = {29'h0, kind};
        end else if (paddr_i == ddgl_pkg::OFS_GEOM) begin
          next_rdata = geom;
        end else if (paddr_i == ddgl_pkg::OFS_RLAT) begin
          next_rdata = {28'h0, rlat};
        end else if (paddr_i == ddgl_pkg::OFS_WLAT) begin
          next_rdata = {29'h0, wlat};
        end else if (paddr_i == ddgl_pkg::OFS_ALAT) begin
          next_rdata = {28'h0, alat};
        end else if (paddr_i == ddgl_pkg::OFS_ACCESS_ENABLE_BIT) begin
          next_rdata = {31'h0, access_enable_bit};
        end else if (paddr_i == ddgl_pkg::OFS_AUTO_REFRESH_ENABLE_BIT) begin
          next_rdata = {31'h0, auto_refresh_enable_bit};
        end else if (paddr_i == ddgl_pkg::OFS_STAT) begin
          next_rdata = status;
        end else begin
          next_rdata = 32'h0000_0000;
        end
      end else begin
        next_err = 1'b0;
      end
    end
  end

  always_comb begin
    next_kind = kind;
    next_geom = geom;
    next_rlat = rlat;
    next_wlat = wlat;
    next_alat = alat;
    next_access_enable_bit = access_enable_bit;
    next_auto_refresh_enable_bit = auto_refresh_enable_bit;
    if (wr_commit) begin
      // reserved bits are dropped on write
      if (paddr_i == ddgl_pkg::OFS_KIND) begin
        next_kind = pwdata_i[2:0];
      end else if (paddr_i == ddgl_pkg::OFS_GEOM) begin
        next_geom = pwdata_i & ddgl_pkg::GEOM_MASK;
      end else if (paddr_i == ddgl_pkg::OFS_RLAT) begin
        next_rlat = pwdata_i[3:0];
      end else if (paddr_i == ddgl_pkg::OFS_WLAT) begin
        next_wlat = pwdata_i[2:0];
      end else if (paddr_i == ddgl_pkg::OFS_ALAT) begin
        next_alat = pwdata_i[3:0];
      end else if (paddr_i == ddgl_pkg::OFS_ACCESS_ENABLE_BIT) begin
        next_access_enable_bit = pwdata_i[0];
      end else if (paddr_i == ddgl_pkg::OFS_AUTO_REFRESH_ENABLE_BIT) begin
        next_auto_refresh_enable_bit = pwdata_i[0];
      end
    end
  end

  // only the power-on reset clears these
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kind <= ddgl_pkg::RESET_VALUE[2:0];
      geom <= ddgl_pkg::RESET_VALUE;
      rlat <= ddgl_pkg::RESET_VALUE[3:0];
      wlat <= ddgl_pkg::RESET_VALUE[2:0];
      alat <= ddgl_pkg::RESET_VALUE[3:0];
      access_enable_bit <= 1'b0;
      auto_refresh_enable_bit <= 1'b0;
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      kind <= next_kind;
      geom <= next_geom;
      rlat <= next_rlat;
      wlat <= next_wlat;
      alat <= next_alat;
      access_enable_bit <= next_access_enable_bit;
      auto_refresh_enable_bit <= next_auto_refresh_enable_bit;
      ack <= next_ack;
      err <= next_err;
      rdata <= next_rdata;
    end
  end

  always_comb begin
    next_ref_cnt = ref_cnt;
    next_ref_pulse = ref_pulse;
    if (ce_i) begin
      next_ref_pulse = 1'b0;
      if (!auto_refresh_enable_bit) begin
        next_ref_cnt = 16'h0000;
      end else if (ref_cnt == ddgl_pkg::REFRESH_LAST) begin
        next_ref_cnt = 16'h0000;
        next_ref_pulse = 1'b1;
      end else begin
        next_ref_cnt = ref_cnt + 16'h0001;
      end
    end
  end

  ddgl_addr_split u_split (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(mem_addr_i),
    .row_width_i(geom[ddgl_pkg::ROW_LSB +: 5]),
    .column_width_i(geom[ddgl_pkg::COL_LSB +: 4]),
    .bank_o(split_bank),
    .row_o(split_row),
    .col_o(split_col)
  );

  assign mem_gnt_o = ce_i & mem_req_i & access_enable_bit;

  always_comb begin
    next_cmd_valid = cmd_valid;
    next_cmd_bank = cmd_bank;
    next_cmd_row = cmd_row;
    next_cmd_col = cmd_col;
    if (ce_i) begin
      next_cmd_valid = mem_gnt_o;
      if (mem_gnt_o) begin
        next_cmd_bank = split_bank;
        next_cmd_row = split_row;
        next_cmd_col = split_col;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_cnt <= 16'h0000;
      ref_pulse <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_bank <= 3'h0;
      cmd_row <= 16'h0000;
      cmd_col <= 12'h000;
    end else begin
      ref_cnt <= next_ref_cnt;
      ref_pulse <= next_ref_pulse;
      cmd_valid <= next_cmd_valid;
      cmd_bank <= next_cmd_bank;
      cmd_row <= next_cmd_row;
      cmd_col <= next_cmd_col;
    end
  end

  assign prdata_o = rdata;
  assign pready_o = ack & ce_i;
  assign pslverr_o = err & ack & ce_i;
  assign memory_kind_code_o = kind;
  assign row_width_o = geom[ddgl_pkg::ROW_LSB +: 5];
  assign rank_count_o = geom[ddgl_pkg::RANK_BIT];
  assign bank_count_o = geom[ddgl_pkg::BANK_LSB +: 2];
  assign column_width_o = geom[ddgl_pkg::COL_LSB +: 4];
  assign ext_bus_width_o = geom[ddgl_pkg::BUSW_LSB +: 2];
  // codes equal sdram clock cycle counts
  assign cas_latency_o = rlat;
  assign cas_write_latency_o = {1'b0, wlat};
  assign additive_latency_o = alat;
  assign access_enable_bit_o = access_enable_bit;
  assign auto_refresh_enable_bit_o = auto_refresh_enable_bit;
  assign config_valid_o = status[ddgl_pkg::STAT_CFG_OK];
  assign cmd_valid_o = cmd_valid;
  assign cmd_bank_o = cmd_bank;
  assign cmd_row_o = cmd_row;
  assign cmd_col_o = cmd_col;
  assign refresh_req_o = ref_pulse;

  property p_kind_flag;
    status[ddgl_pkg::STAT_KIND_OK] == (memory_kind_code_o == 3'h7);
  endproperty
  a_kind_flag: assert property (p_kind_flag) else $error("kind flag wrong");
  property p_cfg_locked;
    (ce_i && psel_i && penable_i && pready_o && pwrite_i && is_cfg(paddr_i) &&
     (access_enable_bit || auto_refresh_enable_bit)) |=> ($stable(geom) && $stable(kind) && $stable(rlat));
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("locked config changed");
  property p_locked_err;
    (access_start && pwrite_i && is_cfg(paddr_i) && (access_enable_bit || auto_refresh_enable_bit)) |=> pslverr_o;
  endproperty
  a_locked_err: assert property (p_locked_err) else $error("no error on locked write");
  property p_geom_write;
    (wr_commit && paddr_i == 8'h04) |=> (geom == ($past(pwdata_i) & 32'h1F13_0F03));
  endproperty
  a_geom_write: assert property (p_geom_write) else $error("geometry not stored");
  property p_row_flag;
    (row_width_o > 5'h10) |-> !config_valid_o;
  endproperty
  a_row_flag: assert property (p_row_flag) else $error("bad row width accepted");
  property p_bank_rank_flag;
    (bank_count_o != 2'h3 || rank_count_o || ext_bus_width_o != 2'h2) |-> !config_valid_o;
  endproperty
  a_bank_rank_flag: assert property (p_bank_rank_flag) else $error("bad geometry accepted");
  property p_lat_flag;
    config_valid_o |-> (cas_latency_o inside {[4'h5:4'hA]} && additive_latency_o == 4'h0 &&
                        cas_write_latency_o inside {[4'h5:4'h7]});
  endproperty
  a_lat_flag: assert property (p_lat_flag) else $error("bad latency accepted");
  property p_gnt_gate;
    mem_gnt_o |-> access_enable_bit_o ##1 (cmd_valid_o && cmd_col_o == $past(split_col));
  endproperty
  a_gnt_gate: assert property (p_gnt_gate) else $error("grant while disabled");
  property p_refresh_gap;
    refresh_req_o |-> $past(auto_refresh_enable_bit) ##1 (!refresh_req_o) [*8];
  endproperty
  a_refresh_gap: assert property (p_refresh_gap) else $error("refresh too close");
  property p_refresh_due;
    (ce_i && auto_refresh_enable_bit && ref_cnt == 16'd155) |=> refresh_req_o;
  endproperty
  a_refresh_due: assert property (p_refresh_due) else $error("refresh not issued");
  c_refresh: cover property (refresh_req_o);
  c_grant: cover property (mem_gnt_o);
  c_locked: cover property (pready_o && pslverr_o);
  c_valid: cover property ($rose(config_valid_o));
endmodule

/* File: ddgl_sdram_model.sv */
// Purpose: far-side stand-in for the sdram parts, counts commands and refreshes
// Assumes: one rank of two x16 or four x8 parts sharing a 32-bit data bus
// Notes: accepts every command at once; array timing is not modelled
`timescale 1ns/1ps
module ddgl_sdram_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic refresh_req_i,
  output logic [15:0] cmd_count_o,
  output logic [15:0] refresh_count_o
);
  logic [15:0] next_cmd_count;
  logic [15:0] next_refresh_count;

  // commands and refresh pulses counted, one per clk_i cycle that each is high
  always_comb begin
    next_cmd_count = cmd_count_o + 16'(cmd_valid_i);
    next_refresh_count = refresh_count_o + 16'(refresh_req_i);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_count_o <= 16'h0000;
      refresh_count_o <= 16'h0000;
    end else begin
      cmd_count_o <= next_cmd_count;
      refresh_count_o <= next_refresh_count;
    end
  end
endmodule

/* File: ddgl_regs_tb_top.sv */
// Purpose: self-checking bench for the sdram kind, geometry and latency registers
// Assumes: apb slave answers after one wait state; ce_i held high throughout
// Notes: prohibited codes are seen through the status word, not blocked
`timescale 1ns/1ps
module ddgl_regs_tb_top;
  logic clk_i, rst_n_i, ce_i, psel_i, penable_i, pwrite_i, mem_req_i, err;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, mem_addr_i, prdata_o, rd, a;
  logic pready_o, pslverr_o, config_valid_o, mem_gnt_o, cmd_valid_o, refresh_req_o;
  logic rank_count_o, access_enable_bit_o, auto_refresh_enable_bit_o;
  logic [1:0] bank_count_o, ext_bus_width_o;
  logic [2:0] memory_kind_code_o;
  logic [3:0] column_width_o, cas_latency_o, cas_write_latency_o, additive_latency_o;
  logic [4:0] row_width_o;
  logic [2:0] cmd_bank_o;
  logic [15:0] cmd_row_o, cmd_count, ref_count, ref_hold;
  logic [11:0] cmd_col_o;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  logic [7:0] offs [8] = '{ddgl_pkg::OFS_KIND, ddgl_pkg::OFS_GEOM, ddgl_pkg::OFS_RLAT,
    ddgl_pkg::OFS_WLAT, ddgl_pkg::OFS_ALAT, ddgl_pkg::OFS_ACCESS_ENABLE_BIT, ddgl_pkg::OFS_AUTO_REFRESH_ENABLE_BIT,
    ddgl_pkg::OFS_STAT};
  logic [31:0] masks [5] = '{ddgl_pkg::KIND_MASK, ddgl_pkg::GEOM_MASK, ddgl_pkg::RLAT_MASK,
    ddgl_pkg::WLAT_MASK, ddgl_pkg::ALAT_MASK};
  logic [31:0] geo_v [12] = '{32'h0A03_0A02, 32'h0B03_0A02, 32'h1003_0A02, 32'h1103_0A02,
    32'h0D13_0A02, 32'h0D02_0A02, 32'h0D03_0702, 32'h0D03_0802, 32'h0D03_0C02,
    32'h0D03_0D02, 32'h0D03_0A01, 32'h0D03_0A03};
  logic geo_ok [12] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  ddgl_regs dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .memory_kind_code_o(memory_kind_code_o), .row_width_o(row_width_o),
    .rank_count_o(rank_count_o), .bank_count_o(bank_count_o),
    .column_width_o(column_width_o), .ext_bus_width_o(ext_bus_width_o),
    .cas_latency_o(cas_latency_o), .cas_write_latency_o(cas_write_latency_o),
    .additive_latency_o(additive_latency_o), .access_enable_bit_o(access_enable_bit_o),
    .auto_refresh_enable_bit_o(auto_refresh_enable_bit_o),
    .config_valid_o(config_valid_o), .mem_req_i(mem_req_i), .mem_addr_i(mem_addr_i),
    .mem_gnt_o(mem_gnt_o), .cmd_valid_o(cmd_valid_o), .cmd_bank_o(cmd_bank_o),
    .cmd_row_o(cmd_row_o), .cmd_col_o(cmd_col_o), .refresh_req_o(refresh_req_o));

  ddgl_sdram_model model_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_o),
    .refresh_req_i(refresh_req_o), .cmd_count_o(cmd_count), .refresh_count_o(ref_count));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // setup edge, access edge, then hold until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int k;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= ad;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    rd = prdata_o;
    err = pslverr_o;
    if (k >= 20) n_mismatch++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr_chk(input logic [7:0] ad, input logic [31:0] wd, input logic e);
    apb(1'b1, ad, wd);
    check({31'h0, err}, {31'h0, e});
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp, input logic e);
    apb(1'b0, ad, 32'h0000_0000);
    check(rd, exp);
    check({31'h0, err}, {31'h0, e});
  endtask

  // bad code clears its own status bit and the all-good bit
  task automatic code_chk(input logic [7:0] ad, input logic [31:0] v, input int b,
                          input logic ok);
    wr_chk(ad, v, 1'b0);
    rd_chk(ddgl_pkg::OFS_STAT, ok ? 32'h0000_003F : (32'h0000_001F & ~(32'h1 << b)), 1'b0);
    check({31'h0, config_valid_o}, {31'h0, ok});
  endtask

  task automatic mem_cycle(input logic [31:0] ad, input logic g);
    @(posedge clk_i);
    mem_req_i <= 1'b1;
    mem_addr_i <= ad;
    @(posedge clk_i);
    check({31'h0, mem_gnt_o}, {31'h0, g});
    mem_req_i <= 1'b0;
    @(posedge clk_i);
    check({31'h0, cmd_valid_o}, {31'h0, g});
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // whole run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end

  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    mem_req_i = 1'b0;
    mem_addr_i = 32'h0000_0000;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // status is derived: a zero additive latency already counts as permitted
    for (int i = 0; i < 8; i++) rd_chk(offs[i], (i == 7) ? 32'h10 : 32'h0, 1'b0);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      wr_chk(offs[i], 32'hFFFF_FFFF, 1'b0);
      rd_chk(offs[i], masks[i], 1'b0);
    end
    $display("test reserved bits done");
    wr_chk(ddgl_pkg::OFS_GEOM, 32'h0D03_0A02, 1'b0);
    wr_chk(ddgl_pkg::OFS_RLAT, 32'h0000_0005, 1'b0);
    wr_chk(ddgl_pkg::OFS_WLAT, 32'h0000_0005, 1'b0);
    wr_chk(ddgl_pkg::OFS_ALAT, 32'h0000_0000, 1'b0);
    for (int c = 0; c < 8; c++) code_chk(ddgl_pkg::OFS_KIND, 32'(c), 0, c == 7);
    for (int i = 0; i < 12; i++) code_chk(ddgl_pkg::OFS_GEOM, geo_v[i], 1, geo_ok[i]);
    code_chk(ddgl_pkg::OFS_GEOM, 32'h0D03_0A02, 1, 1'b1);
    for (int c = 0; c < 16; c++) code_chk(ddgl_pkg::OFS_RLAT, 32'(c), 2, c >= 5 && c <= 10);
    code_chk(ddgl_pkg::OFS_RLAT, 32'h0000_0005, 2, 1'b1);
    for (int c = 0; c < 8; c++) code_chk(ddgl_pkg::OFS_WLAT, 32'(c), 3, c >= 5);
    for (int c = 15; c >= 0; c--) code_chk(ddgl_pkg::OFS_ALAT, 32'(c), 4, c == 0);
    check({24'h0, memory_kind_code_o, row_width_o}, {24'h0, 3'h7, 5'h0D});
    check({23'h0, rank_count_o, bank_count_o, column_width_o, ext_bus_width_o}, 32'hEA);
    check({20'h0, cas_latency_o, cas_write_latency_o, additive_latency_o}, 32'h570);
    $display("test code sweep done");
    rd_chk(8'h20, 32'h0000_0000, 1'b1);
    wr_chk(8'h20, 32'hFFFF_FFFF, 1'b1);
    wr_chk(ddgl_pkg::OFS_STAT, 32'h0000_0000, 1'b0);
    rd_chk(ddgl_pkg::OFS_STAT, 32'h0000_003F, 1'b0);
    $display("test unmapped done");
    a = 32'h0012_3458;
    mem_cycle(a, 1'b0);
    wr_chk(ddgl_pkg::OFS_ACCESS_ENABLE_BIT, 32'h0000_0001, 1'b0);
    mem_cycle(a, 1'b1);
    check({20'h0, cmd_col_o}, (a >> 2) & 32'h0000_03FF);
    check({29'h0, cmd_bank_o}, (a >> 12) & 32'h0000_0007);
    check({16'h0, cmd_row_o}, (a >> 15) & 32'h0000_1FFF);
    check({30'h0, access_enable_bit_o, auto_refresh_enable_bit_o}, 32'h2);
    // the model counts on this edge, so look one cycle later
    @(posedge clk_i);
    check({16'h0, cmd_count}, 32'h0000_0001);
    wr_chk(ddgl_pkg::OFS_KIND, 32'h0000_0000, 1'b1);
    rd_chk(ddgl_pkg::OFS_KIND, 32'h0000_0007, 1'b0);
    wr_chk(ddgl_pkg::OFS_ACCESS_ENABLE_BIT, 32'h0000_0000, 1'b0);
    mem_cycle(a, 1'b0);
    check({16'h0, cmd_count}, 32'h0000_0001);
    $display("test access enable done");
    wr_chk(ddgl_pkg::OFS_AUTO_REFRESH_ENABLE_BIT, 32'h0000_0001, 1'b0);
    n = 0;
    while (refresh_req_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (refresh_req_o !== 1'b1 && n < 400);
    check(32'(n), 32'(ddgl_pkg::REFRESH_CYCLES));
    check({30'h0, access_enable_bit_o, auto_refresh_enable_bit_o}, 32'h1);
    wr_chk(ddgl_pkg::OFS_RLAT, 32'h0000_0006, 1'b1);
    rd_chk(ddgl_pkg::OFS_RLAT, 32'h0000_0005, 1'b0);
    wr_chk(ddgl_pkg::OFS_AUTO_REFRESH_ENABLE_BIT, 32'h0000_0000, 1'b0);
    ref_hold = ref_count;
    repeat (400) @(posedge clk_i);
    check({16'h0, ref_count}, {16'h0, ref_hold});
    $display("test refresh done");
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(offs[i], (i == 7) ? 32'h10 : 32'h0, 1'b0);
    $display("test second reset done");
    test_done();
  end
endmodule
